// ===== hdl/dac_mode_pkg.sv
// How it works
// - mode 000 disables everything, opens all switches
// - reset leaves mode at 000 off
// - mode 001 amplifier only, switch one closed
// - mode 010 ladder only, all switches open
// - mode 100 ladder, switch three closed
// - mode 101 both, switches one and three closed
// - mode 111 both, switch two closed
// - ladder enabled drives internal level node
// - reduced range: code*0.8/256 plus 0.1 span
// - full range: code*span/256 above ref_low
// - reset selects full voltage range
// - unsupported mode writes keep the mode but still write range and drive
package dac_mode_pkg;

  // ==========================================
  // register map, word index = byte address / 4
  localparam logic [2:0] CTRL_IDX   = 3'h0;  // control register
  localparam logic [2:0] LEVEL_IDX  = 3'h2;  // level code register
  localparam int         ADDR_W     = 5;     // byte address width

  // ==========================================
  // control register fields
  localparam int         RANGE_BIT  = 7;     // full range select
  localparam int         DRIVE_BIT  = 6;     // amplifier drive select
  localparam int         MODE_LSB   = 0;     // mode field low bit
  localparam int         MODE_W     = 3;     // mode field width

  // ==========================================
  // values after reset
  localparam logic       RANGE_RST  = 1'h1;  // full range
  localparam logic       DRIVE_RST  = 1'h0;  // low drive
  localparam logic [7:0] LEVEL_RST  = 8'h00; // level code

  // ==========================================
  // mode codes
  typedef enum logic [2:0] {
    MODE_OFF   = 3'h0,  // everything off
    MODE_AMP   = 3'h1,  // amplifier only
    MODE_INT   = 3'h2,  // internal ladder only
    MODE_UNBUF = 3'h4,  // ladder to unbuffered pin
    MODE_BOTH  = 3'h5,  // ladder and free amplifier
    MODE_BUF   = 3'h7   // amplifier buffers ladder
  } mode_t;

  // ==========================================
  // level scaling in units of span/2560
  localparam logic [11:0] FULL_MUL  = 12'h00a; // 10 units per code step
  localparam logic [11:0] RED_MUL   = 12'h008; // 8 units per code step
  localparam logic [11:0] RED_OFS   = 12'h100; // 256 units = 0.1 span

endpackage : dac_mode_pkg

// ===== hdl/dac_mode_control.sv
`timescale 1ns/1ns
module dac_mode_control (
  input  wire logic        mclk,           // 10 mhz system clock
  input  wire logic        rst,            // synchronous reset, high
  input  wire logic        ce,             // clock enable, low freezes
  input  wire logic [4:0]  address,        // avalon byte address
  input  wire logic        read,           // avalon read
  input  wire logic        write,          // avalon write
  input  wire logic [31:0] writedata,      // avalon write data
  input  wire logic [3:0]  byteenable,     // avalon byte enables
  output logic      [31:0] readdata,       // avalon read data
  output logic             waitrequest,    // avalon wait
  output logic             ladder_en_q,    // resistor network enable
  output logic             amp_en_q,       // amplifier enable
  output logic             switch_one_q,   // 1 = switch one closed
  output logic             switch_two_q,   // 1 = switch two closed
  output logic             switch_three_q, // 1 = switch three closed
  output logic             node_en_q,      // internal level node live
  output logic             drive_high_q,   // amplifier high drive
  output logic             range_select_q, // 1 = full range
  output logic      [7:0]  level_code_q,   // ladder level code
  output logic      [11:0] level_frac_q    // output in span/2560 above ref_low
);

  // ==========================================
  // helper functions

  // decode mode into {ladder, amp, s1, s2, s3}
  function automatic logic [4:0] decode(input logic [2:0] m);
    logic [4:0] r;
    r = 5'h00;
    case (m)
      dac_mode_pkg::MODE_OFF:   r = 5'b00000;
      dac_mode_pkg::MODE_AMP:   r = 5'b01100;
      dac_mode_pkg::MODE_INT:   r = 5'b10000;
      dac_mode_pkg::MODE_UNBUF: r = 5'b10001;
      dac_mode_pkg::MODE_BOTH:  r = 5'b11101;
      dac_mode_pkg::MODE_BUF:   r = 5'b11010;
      default:                  r = 5'b00000; // never stored
    endcase
    return r;
  endfunction : decode

  // true for the six documented codes
  function automatic logic supported(input logic [2:0] m);
    logic ok;
    ok = 1'b0;
    case (m)
      dac_mode_pkg::MODE_OFF,
      dac_mode_pkg::MODE_AMP,
      dac_mode_pkg::MODE_INT,
      dac_mode_pkg::MODE_UNBUF,
      dac_mode_pkg::MODE_BOTH,
      dac_mode_pkg::MODE_BUF: ok = 1'b1;
      default:                ok = 1'b0;
    endcase
    return ok;
  endfunction : supported

  // level in span/2560 units for both ranges
  function automatic logic [11:0] scale(input logic [7:0] c,
                                        input logic       full);
    logic [11:0] v;
    v = 12'h000;
    if (full) begin
      v = 12'(c * dac_mode_pkg::FULL_MUL);
    end else begin
      v = 12'(c * dac_mode_pkg::RED_MUL) + dac_mode_pkg::RED_OFS;
    end
    return v;
  endfunction : scale

  // ==========================================
  // bus slave state
  logic        ack_q;       // second cycle of a request
  logic        ack_d;
  logic [31:0] rdata_q;     // read data register
  logic [31:0] rdata_d;
  logic [2:0]  mode_q;      // stored mode code
  logic [2:0]  mode_d;
  logic        range_q;     // stored range bit
  logic        range_d;
  logic        drive_q;     // stored drive bit
  logic        drive_d;
  logic [7:0]  code_q;      // stored level code
  logic [7:0]  code_d;
  logic        req;         // request present
  logic        aligned;     // word aligned address
  logic [2:0]  idx;         // word index
  logic        wr_go;       // write taken this edge
  logic [2:0]  wmode;       // mode field of write data

  assign req         = read | write;
  assign aligned     = (address[1:0] == 2'h0);
  assign idx         = address[4:2];
  assign wmode       = writedata[dac_mode_pkg::MODE_LSB +: dac_mode_pkg::MODE_W];
  // one wait cycle, then the request completes
  assign waitrequest = req & ~ack_q;
  assign wr_go       = write & ack_q & ce;
  assign readdata    = rdata_q;

  // ==========================================
  // bus next values
  always_comb begin
    ack_d   = ack_q;
    rdata_d = rdata_q;
    mode_d  = mode_q;
    range_d = range_q;
    drive_d = drive_q;
    code_d  = code_q;
    // ack toggles once per request
    ack_d = req & ~ack_q;
    // read data gathered in the wait cycle
    if (read & ~ack_q) begin
      rdata_d = 32'h0000_0000;
      if (aligned && idx == dac_mode_pkg::CTRL_IDX) begin
        rdata_d[dac_mode_pkg::RANGE_BIT] = range_q;
        rdata_d[dac_mode_pkg::DRIVE_BIT] = drive_q;
        rdata_d[dac_mode_pkg::MODE_LSB +: dac_mode_pkg::MODE_W] = mode_q;
      end else if (aligned && idx == dac_mode_pkg::LEVEL_IDX) begin
        rdata_d[7:0] = code_q;
      end
    end
    // writes land on the completing edge
    if (write & ack_q & byteenable[0] & aligned) begin
      if (idx == dac_mode_pkg::CTRL_IDX) begin
        range_d = writedata[dac_mode_pkg::RANGE_BIT];
        drive_d = writedata[dac_mode_pkg::DRIVE_BIT];
        // reserved codes leave the mode alone
        if (supported(wmode)) begin
          mode_d = wmode;
        end
      end else if (idx == dac_mode_pkg::LEVEL_IDX) begin
        code_d = writedata[7:0];
      end
    end
  end

  // bus registers, reset wins over enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      mode_q  <= dac_mode_pkg::MODE_OFF;
      range_q <= dac_mode_pkg::RANGE_RST;
      drive_q <= dac_mode_pkg::DRIVE_RST;
      code_q  <= dac_mode_pkg::LEVEL_RST;
    end else if (ce) begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      mode_q  <= mode_d;
      range_q <= range_d;
      drive_q <= drive_d;
      code_q  <= code_d;
    end
  end

  // ==========================================
  // decoded control outputs
  logic [4:0]  dec_d;      // {ladder, amp, s1, s2, s3}
  logic        node_d;     // internal node enable
  logic [11:0] frac_d;     // scaled level

  // decode from stored settings
  always_comb begin
    dec_d  = decode(mode_q);
    node_d = dec_d[4];
    frac_d = scale(code_q, range_q);
  end

  // outputs lag the stored settings by one edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      ladder_en_q    <= 1'b0;
      amp_en_q       <= 1'b0;
      switch_one_q   <= 1'b0;
      switch_two_q   <= 1'b0;
      switch_three_q <= 1'b0;
      node_en_q      <= 1'b0;
      drive_high_q   <= dac_mode_pkg::DRIVE_RST;
      range_select_q <= dac_mode_pkg::RANGE_RST;
      level_code_q   <= dac_mode_pkg::LEVEL_RST;
      level_frac_q   <= 12'h000;
    end else if (ce) begin
      ladder_en_q    <= dec_d[4];
      amp_en_q       <= dec_d[3];
      switch_one_q   <= dec_d[2];
      switch_two_q   <= dec_d[1];
      switch_three_q <= dec_d[0];
      node_en_q      <= node_d;
      drive_high_q   <= drive_q;
      range_select_q <= range_q;
      level_code_q   <= code_q;
      level_frac_q   <= frac_d;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || !ce);

  logic [4:0] outs;  // decoded outputs gathered
  assign outs = {ladder_en_q, amp_en_q, switch_one_q, switch_two_q, switch_three_q};

  sequence ctrl_write_s;
    wr_go && byteenable[0] && aligned && idx == dac_mode_pkg::CTRL_IDX;
  endsequence

  sequence good_write_s;
    ctrl_write_s ##0 supported(wmode);
  endsequence

  sequence bad_write_s;
    ctrl_write_s ##0 !supported(wmode);
  endsequence

  // mode decodes, one edge later
  off_decode_a: assert property ((mode_q == 3'h0) |=> outs == 5'b00000)
    else $error("off mode outputs wrong");
  amp_decode_a: assert property ((mode_q == 3'h1) |=> outs == 5'b01100)
    else $error("amplifier mode outputs wrong");
  int_decode_a: assert property ((mode_q == 3'h2) |=> outs == 5'b10000)
    else $error("internal mode outputs wrong");
  unbuf_decode_a: assert property ((mode_q == 3'h4) |=> outs == 5'b10001)
    else $error("unbuffered mode outputs wrong");
  both_decode_a: assert property ((mode_q == 3'h5) |=> outs == 5'b11101)
    else $error("combined mode outputs wrong");
  buf_decode_a: assert property ((mode_q == 3'h7) |=> outs == 5'b11010)
    else $error("buffered mode outputs wrong");

  // reset state of mode and range
  reset_mode_a: assert property ($fell(rst) |-> mode_q == 3'h0 && range_q)
    else $error("mode not off after reset");
  reset_range_a: assert property ($fell(rst) |-> range_select_q == 1'b1)
    else $error("range not full after reset");

  // internal node follows the ladder enable
  node_follow_a: assert property (node_en_q == ladder_en_q)
    else $error("internal node disagrees with ladder");

  // scaled level in both ranges
  reduced_level_a: assert property (!range_q |=>
      level_frac_q == 12'($past(code_q)) * 12'h008 + 12'h100)
    else $error("reduced range level wrong");
  full_level_a: assert property (range_q |=>
      level_frac_q == 12'($past(code_q)) * 12'h00a)
    else $error("full range level wrong");

  // reserved codes leave mode_q unchanged on the next edge and the decoded outputs on the one after
  bad_mode_a: assert property (bad_write_s |=> $stable(mode_q) ##1 $stable(outs))
    else $error("reserved mode write took effect");

  // accepted write reaches mode_q on the next edge and the decoded outputs on the edge after
  write_lag_a: assert property (good_write_s |=>
      mode_q == $past(wmode) ##1 outs == decode($past(wmode, 2)))
    else $error("decoded outputs did not follow write");

endmodule : dac_mode_control

// ===== bench/dac_mode_control_tb.sv
`timescale 1ns/1ns
module dac_mode_control_tb;
  // ==========================================
  // stimulus and observed signals
  logic        mclk;           // system clock
  logic        rst;            // reset, high
  logic        ce;             // clock enable
  logic [4:0]  address;        // byte address
  logic        read;           // read strobe
  logic        write;          // write strobe
  logic [31:0] writedata;      // write data
  logic [3:0]  byteenable;     // byte enables
  logic [31:0] readdata;       // read data
  logic        waitrequest;    // bus wait
  logic        ladder_en_q;    // network enable
  logic        amp_en_q;       // amplifier enable
  logic        switch_one_q;   // switch one closed
  logic        switch_two_q;   // switch two closed
  logic        switch_three_q; // switch three closed
  logic        node_en_q;      // internal node live
  logic [7:0]  level_code_q;   // level code
  logic [11:0] level_frac_q;   // output level
  logic        range_select_q; // full range
  logic        drive_high_q;   // amplifier high drive
  int          n_fail;         // mismatches
  int          checked;        // comparisons
  logic [31:0] rd;             // last read word
  logic [2:0]  mode_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7}; // supported codes
  logic [4:0]  dec_tab  [6] = '{5'h00, 5'h0c, 5'h10, 5'h11, 5'h1d, 5'h1a}; // net,amp,s1,s2,s3
  logic [7:0]  code_tab [3] = '{8'h00, 8'h80, 8'hff}; // level boundaries

  dac_mode_control uut (
    .mclk(mclk), .rst(rst), .ce(ce), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .ladder_en_q(ladder_en_q), .amp_en_q(amp_en_q),
    .switch_one_q(switch_one_q), .switch_two_q(switch_two_q),
    .switch_three_q(switch_three_q), .node_en_q(node_en_q), .drive_high_q(drive_high_q),
    .range_select_q(range_select_q), .level_code_q(level_code_q),
    .level_frac_q(level_frac_q)
  );

  // ==========================================
  // clock, one flip each half period
  always #50 mclk = ~mclk;

  // ==========================================
  // helpers
  // compare and count, report at once
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // one avalon cycle, held until wait drops
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    address    <= a;
    writedata  <= {24'h0, d};
    byteenable <= be;
    read       <= ~wr;
    write      <= wr;
    // wait is judged as it stands at each rising edge
    do begin
      @(posedge mclk);
      n++;
      if (n > 20) begin
        n_fail++;
        wrap_up();
      end
    end while (waitrequest !== 1'b0);
    // data taken and request dropped at the completing edge
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // decoded enables and switches against a pattern
  task outs(input logic [4:0] e);
    logic [4:0] seen;
    seen = {ladder_en_q, amp_en_q, switch_one_q, switch_two_q, switch_three_q};
    check("decode", seen, e);
    check("node", node_en_q, e[4]);
  endtask : outs

  // summary, verdict and end of run
  task wrap_up();
    $display("counts: %0d checks, %0d mismatches", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // ==========================================
  // watchdog, far beyond the fewer than two hundred cycles needed
  initial begin
    #(100 * 3000);
    n_fail++;
    wrap_up();
  end

  // ==========================================
  // main sequence
  initial begin
    mclk = 0; rst = 1; ce = 1; address = 0; read = 0; write = 0;
    writedata = 0; byteenable = 4'h1; n_fail = 0; checked = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    // state straight after reset
    outs(5'h00);
    check("range", range_select_q, 1'b1);
    bus(1'b0, 5'h00, 8'h00, 4'h1);
    check("ctrl reset", rd, 32'h80);
    $display("test reset done");
    // every supported mode, one edge of lag
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 5'h00, {5'h10, mode_tab[i]}, 4'h1);
      @(negedge mclk);
      outs(i == 0 ? 5'h00 : dec_tab[i - 1]);
      @(negedge mclk);
      outs(dec_tab[i]);
      bus(1'b0, 5'h00, 8'h00, 4'h1);
      check("ctrl mode", rd, {24'h0, 5'h10, mode_tab[i]});
    end
    $display("test modes done");
    // reserved codes keep the buffered mode
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 5'h00, (i == 0) ? 8'h03 : 8'h06, 4'h1);
      repeat (2) @(negedge mclk);
      outs(5'h1a);
      bus(1'b0, 5'h00, 8'h00, 4'h1);
      check("ctrl reserved", rd, 32'h07);
    end
    $display("test reserved done");
    // level codes at both ends and middle, both ranges
    for (int j = 0; j < 3; j++) begin
      for (int r = 0; r < 2; r++) begin
        bus(1'b1, 5'h00, {r[0], 7'h07}, 4'h1);
        bus(1'b1, 5'h08, code_tab[j], 4'h1);
        repeat (2) @(negedge mclk);
        check("code", level_code_q, code_tab[j]);
        check("frac", level_frac_q, (r == 1) ? code_tab[j] * 12'd10
                                             : code_tab[j] * 12'd8 + 12'd256);
        bus(1'b0, 5'h08, 8'h00, 4'h1);
        check("level read", rd, {24'h0, code_tab[j]});
      end
    end
    $display("test levels done");
    // masked, misaligned and unmapped accesses
    bus(1'b1, 5'h00, 8'h80, 4'h0);
    bus(1'b1, 5'h0c, 8'h80, 4'h1);
    bus(1'b0, 5'h00, 8'h00, 4'h1);
    check("ctrl kept", rd, 32'h87);
    bus(1'b0, 5'h0c, 8'h00, 4'h1);
    check("unmapped", rd, 32'h0);
    bus(1'b0, 5'h01, 8'h00, 4'h1);
    check("misaligned", rd, 32'h0);
    // drive bit written, read back and shown
    bus(1'b1, 5'h00, 8'hc7, 4'h1);
    bus(1'b0, 5'h00, 8'h00, 4'h1);
    check("ctrl drive", rd, 32'hc7);
    check("drive", drive_high_q, 1'b1);
    // back to off mode, outputs frozen while ce is low
    bus(1'b1, 5'h00, 8'h80, 4'h1);
    ce <= 1'b0;
    repeat (3) @(negedge mclk);
    outs(5'h1a);
    check("drive frozen", drive_high_q, 1'b1);
    @(posedge mclk);
    ce <= 1'b1;
    repeat (2) @(negedge mclk);
    outs(5'h00);
    check("drive off", drive_high_q, 1'b0);
    $display("test access done");
    wrap_up();
  end
endmodule : dac_mode_control_tb
